// ---- logic/amp_ctl_pkg.sv ----
// constants, offsets and state encoding shared by the amplifier control master
package amp_ctl_pkg;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_SCL_MIN_NS = 2500;
  localparam int T_HOLD_NS = 100;
  // half of the shortest allowed period, rounded up so the rate stays under the limit
  localparam int SCL_HALF_CYC = (T_SCL_MIN_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 7;
  // ***************************************************************
  // chip address
  // ***************************************************************
  localparam logic [5:0] ADDR_PREFIX = 6'h3E;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ***************************************************************
  // wishbone register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_SPATIAL = 8'h10;
  localparam logic [7:0] OFS_MONO = 8'h14;
  localparam logic [7:0] OFS_LEFT = 8'h18;
  localparam logic [7:0] OFS_RIGHT = 8'h1C;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_LEVEL_BIT = 1;
  localparam logic [7:0] SHADOW_RST = 8'h00;
  // ***************************************************************
  // data byte decode
  // ***************************************************************
  localparam logic [1:0] TAG_SPATIAL = 2'h1;
  localparam logic [2:0] TAG_MONO = 3'h4;
  localparam logic [2:0] TAG_LEFT = 3'h6;
  localparam logic [2:0] TAG_RIGHT = 3'h7;
  // ***************************************************************
  // link state, gray along the usual path except the STOPR to IDLE step
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_LOW = 4'h3,
    ST_HIGH = 4'h2,
    ST_ACKL = 4'h6,
    ST_ACKH = 4'h7,
    ST_STOPL = 4'h5,
    ST_STOPH = 4'h4,
    ST_STOPR = 4'hC
  } link_st_t;
endpackage : amp_ctl_pkg

// ---- logic/half_tmr_if.sv ----
// half-period timer handshake between the sequencer and its timer
`timescale 1ns/10ps
interface half_tmr_if #(parameter int W = 7);
  logic en;
  logic tick;
  logic [W-1:0] cnt;
  modport timer (input en, output tick, output cnt);
  modport user (output en, input tick, input cnt);
endinterface : half_tmr_if

// ---- logic/in_sync.sv ----
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module in_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // idle bus level is high, so reset to ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule : in_sync

// ---- logic/half_tmr.sv ----
// counts one half of a serial clock period while enabled
`timescale 1ns/10ps
module half_tmr #(
  parameter int W = 7,
  parameter int HALF = 63
) (
  input wire logic clk_i,
  input wire logic rst_i,
  half_tmr_if.timer t
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick;
  always_comb begin
    tick = t.en && (cnt_q == W'(HALF - 1));
    if (!t.en || tick) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign t.tick = tick;
  assign t.cnt = cnt_q;
endmodule : half_tmr

// ---- logic/amp_ctl_master.sv ----
// wishbone-driven two-wire master that programs the amplifier control registers
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module amp_ctl_master (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic scl_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  // ***************************************************************
  // declarations
  // ***************************************************************
  amp_ctl_pkg::link_st_t state_q, state_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic byte_sel_q, byte_sel_d;
  logic addr_nack_q, addr_nack_d;
  logic data_nack_q, data_nack_d;
  logic done_q, done_d;
  logic scl_q, scl_d;
  logic sda_oe_q, sda_oe_d;
  logic sda_lo_q;
  logic byte_taken;
  logic sda_s;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic go_q, go_d;
  logic level_q, level_d;
  logic [7:0] data_q, data_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] spat_q, spat_d;
  logic [4:0] mono_q, mono_d;
  logic [4:0] left_q, left_d;
  logic [4:0] right_q, right_d;
  logic wb_req;
  logic wb_wr;
  logic idle;
  half_tmr_if #(.W(amp_ctl_pkg::TMR_W)) tmr ();
  // ***************************************************************
  // helpers
  // ***************************************************************
  in_sync #(.W(1)) u_sda_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );
  half_tmr #(
    .W(amp_ctl_pkg::TMR_W),
    .HALF(amp_ctl_pkg::SCL_HALF_CYC)
  ) u_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .t(tmr.timer)
  );
  assign tmr.en = (state_q != amp_ctl_pkg::ST_IDLE);
  assign idle = (state_q == amp_ctl_pkg::ST_IDLE) && !go_q;
  // ***************************************************************
  // link sequencer
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shreg_d = shreg_q;
    byte_sel_d = byte_sel_q;
    addr_nack_d = addr_nack_q;
    data_nack_d = data_nack_q;
    done_d = done_q;
    byte_taken = 1'b0;
    case (state_q)
      amp_ctl_pkg::ST_IDLE: begin
        if (go_q) begin
          state_d = amp_ctl_pkg::ST_START;
          shreg_d = {amp_ctl_pkg::ADDR_PREFIX, level_q, 1'b0};
          bit_cnt_d = amp_ctl_pkg::LAST_BIT;
          byte_sel_d = 1'b0;
          addr_nack_d = 1'b0;
          data_nack_d = 1'b0;
          done_d = 1'b0;
        end
      end
      amp_ctl_pkg::ST_START: begin
        if (tmr.tick) begin
          state_d = amp_ctl_pkg::ST_LOW;
        end
      end
      amp_ctl_pkg::ST_LOW: begin
        if (tmr.tick) begin
          state_d = amp_ctl_pkg::ST_HIGH;
        end
      end
      amp_ctl_pkg::ST_HIGH: begin
        if (tmr.tick) begin
          shreg_d = {shreg_q[6:0], 1'b0};
          bit_cnt_d = bit_cnt_q - 3'h1;
          if (bit_cnt_q == 3'h0) begin
            state_d = amp_ctl_pkg::ST_ACKL;
          end else begin
            state_d = amp_ctl_pkg::ST_LOW;
          end
        end
      end
      amp_ctl_pkg::ST_ACKL: begin
        if (tmr.tick) begin
          state_d = amp_ctl_pkg::ST_ACKH;
        end
      end
      amp_ctl_pkg::ST_ACKH: begin
        if (tmr.tick) begin
          if (!byte_sel_q) begin
            if (sda_s) begin
              addr_nack_d = 1'b1;
              state_d = amp_ctl_pkg::ST_STOPL;
            end else begin
              byte_sel_d = 1'b1;
              shreg_d = data_q;
              bit_cnt_d = amp_ctl_pkg::LAST_BIT;
              state_d = amp_ctl_pkg::ST_LOW;
            end
          end else begin
            data_nack_d = sda_s;
            byte_taken = !sda_s;
            state_d = amp_ctl_pkg::ST_STOPL;
          end
        end
      end
      amp_ctl_pkg::ST_STOPL: begin
        if (tmr.tick) begin
          state_d = amp_ctl_pkg::ST_STOPH;
        end
      end
      amp_ctl_pkg::ST_STOPH: begin
        if (tmr.tick) begin
          state_d = amp_ctl_pkg::ST_STOPR;
        end
      end
      amp_ctl_pkg::ST_STOPR: begin
        if (tmr.tick) begin
          state_d = amp_ctl_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = amp_ctl_pkg::ST_IDLE;
      end
    endcase
  end
  // ***************************************************************
  // pin drive
  // ***************************************************************
  always_comb begin
    case (state_d)
      amp_ctl_pkg::ST_LOW, amp_ctl_pkg::ST_ACKL, amp_ctl_pkg::ST_STOPL: scl_d = 1'b0;
      default: scl_d = 1'b1;
    endcase
    sda_oe_d = sda_oe_q;
    // data moves in low halves after the hold time; only the START and STOPR edges move it while clock is high
    case (state_q)
      amp_ctl_pkg::ST_IDLE: sda_oe_d = 1'b0;
      amp_ctl_pkg::ST_START: sda_oe_d = 1'b1;
      amp_ctl_pkg::ST_LOW: begin
        if (tmr.cnt >= amp_ctl_pkg::TMR_W'(amp_ctl_pkg::HOLD_CYC)) begin
          sda_oe_d = !shreg_q[7];
        end
      end
      amp_ctl_pkg::ST_ACKL: begin
        if (tmr.cnt >= amp_ctl_pkg::TMR_W'(amp_ctl_pkg::HOLD_CYC)) begin
          sda_oe_d = 1'b0;
        end
      end
      amp_ctl_pkg::ST_STOPL: begin
        if (tmr.cnt >= amp_ctl_pkg::TMR_W'(amp_ctl_pkg::HOLD_CYC)) begin
          sda_oe_d = 1'b1;
        end
      end
      amp_ctl_pkg::ST_STOPR: sda_oe_d = 1'b0;
      default: sda_oe_d = sda_oe_q;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= amp_ctl_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      shreg_q <= 8'h00;
      byte_sel_q <= 1'b0;
      addr_nack_q <= 1'b0;
      data_nack_q <= 1'b0;
      done_q <= 1'b0;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      sda_lo_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shreg_q <= shreg_d;
      byte_sel_q <= byte_sel_d;
      addr_nack_q <= addr_nack_d;
      data_nack_q <= data_nack_d;
      done_q <= done_d;
      scl_q <= scl_d;
      sda_oe_q <= sda_oe_d;
      sda_lo_q <= 1'b0;
    end
  end
  assign scl_o = scl_q;
  assign sda_oe_o = sda_oe_q;
  assign sda_o = sda_lo_q;
  // ***************************************************************
  // wishbone slave and shadow copies
  // ***************************************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  always_comb begin
    ack_d = wb_req;
    dat_d = dat_q;
    go_d = 1'b0;
    level_d = level_q;
    data_d = data_q;
    mode_d = mode_q;
    spat_d = spat_q;
    mono_d = mono_q;
    left_d = left_q;
    right_d = right_q;
    // writes while a transfer runs are ignored so the byte on the wire stays intact
    if (wb_wr && idle) begin
      if (wb_adr_i == amp_ctl_pkg::OFS_CTRL) begin
        go_d = wb_dat_i[amp_ctl_pkg::CTRL_GO_BIT];
        level_d = wb_dat_i[amp_ctl_pkg::CTRL_LEVEL_BIT];
      end
      if (wb_adr_i == amp_ctl_pkg::OFS_DATA) begin
        data_d = wb_dat_i[7:0];
      end
    end
    if (wb_req) begin
      case (wb_adr_i)
        amp_ctl_pkg::OFS_CTRL: dat_d = {30'h0, level_q, 1'b0};
        amp_ctl_pkg::OFS_DATA: dat_d = {24'h0, data_q};
        amp_ctl_pkg::OFS_STATUS: dat_d = {28'h0, done_q, data_nack_q, addr_nack_q, !idle};
        amp_ctl_pkg::OFS_MODE: dat_d = {24'h0, mode_q};
        amp_ctl_pkg::OFS_SPATIAL: dat_d = {24'h0, spat_q};
        amp_ctl_pkg::OFS_MONO: dat_d = {27'h0, mono_q};
        amp_ctl_pkg::OFS_LEFT: dat_d = {27'h0, left_q};
        amp_ctl_pkg::OFS_RIGHT: dat_d = {27'h0, right_q};
        default: dat_d = 32'h0;
      endcase
    end
    // copies track only bytes the device acknowledged
    if (byte_taken) begin
      if (!data_q[7] && !data_q[6] && !data_q[4]) begin
        mode_d = data_q;
      end else if (data_q[7:6] == amp_ctl_pkg::TAG_SPATIAL) begin
        spat_d = data_q;
      end else if (data_q[7:5] == amp_ctl_pkg::TAG_MONO) begin
        mono_d = data_q[4:0];
      end else if (data_q[7:5] == amp_ctl_pkg::TAG_LEFT) begin
        left_d = data_q[4:0];
      end else if (data_q[7:5] == amp_ctl_pkg::TAG_RIGHT) begin
        right_d = data_q[4:0];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      go_q <= 1'b0;
      level_q <= 1'b0;
      data_q <= amp_ctl_pkg::SHADOW_RST;
      mode_q <= amp_ctl_pkg::SHADOW_RST;
      spat_q <= amp_ctl_pkg::SHADOW_RST;
      mono_q <= 5'h00;
      left_q <= 5'h00;
      right_q <= 5'h00;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      go_q <= go_d;
      level_q <= level_d;
      data_q <= data_d;
      mode_q <= mode_d;
      spat_q <= spat_d;
      mono_q <= mono_d;
      left_q <= left_d;
      right_q <= right_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_start;
    state_q == amp_ctl_pkg::ST_START && $past(state_q) == amp_ctl_pkg::ST_START
      |-> scl_q && sda_oe_q;
  endproperty
  a_start: assert property (p_start) else $error("start not low data on high clock");
  property p_addr_byte;
    state_q == amp_ctl_pkg::ST_HIGH && tmr.tick && bit_cnt_q == 3'h0
      |=> state_q == amp_ctl_pkg::ST_ACKL;
  endproperty
  a_addr_byte: assert property (p_addr_byte) else $error("no ack slot after 8 bits");
  property p_stable;
    scl_q && $past(scl_q) && state_q inside {amp_ctl_pkg::ST_HIGH, amp_ctl_pkg::ST_ACKH}
      |-> $stable(sda_oe_q);
  endproperty
  a_stable: assert property (p_stable) else $error("data moved while clock high");
  property p_release;
    state_q == amp_ctl_pkg::ST_ACKH |-> !sda_oe_q && scl_q;
  endproperty
  a_release: assert property (p_release) else $error("data driven in ack pulse");
  property p_abort;
    $rose(addr_nack_q) |-> state_q == amp_ctl_pkg::ST_STOPL && !byte_sel_q;
  endproperty
  a_abort: assert property (p_abort) else $error("address refusal not aborted");
  property p_data_follows;
    state_q == amp_ctl_pkg::ST_ACKH && tmr.tick && !byte_sel_q && !sda_s
      |=> state_q == amp_ctl_pkg::ST_LOW && byte_sel_q && bit_cnt_q == 3'h7;
  endproperty
  a_data_follows: assert property (p_data_follows) else $error("data byte not sent");
  property p_data_ack;
    state_q == amp_ctl_pkg::ST_ACKH && tmr.tick && byte_sel_q
      |=> state_q == amp_ctl_pkg::ST_STOPL && data_nack_q == $past(sda_s);
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("data ack not checked");
  property p_stop;
    state_q == amp_ctl_pkg::ST_STOPR |=> scl_q && !sda_oe_q;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not rising data on high clock");
  property p_idle;
    state_q == amp_ctl_pkg::ST_IDLE && $past(state_q) == amp_ctl_pkg::ST_IDLE
      |-> scl_q && !sda_oe_q;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not released when idle");
  property p_low_only;
    !sda_lo_q;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data driven high");
  property p_rate;
    $changed(scl_q) |=> $stable(scl_q)[*8];
  endproperty
  a_rate: assert property (p_rate) else $error("serial clock too fast");
  property p_wb;
    wb_cyc_i && wb_stb_i && !ack_q |=> ack_q ##1 !ack_q;
  endproperty
  a_wb: assert property (p_wb) else $error("bus answer not a single cycle");
  c_done: cover property ($rose(done_q) && !data_nack_q);
  c_addr_nack: cover property ($rose(addr_nack_q));
  c_mode: cover property (byte_taken && !data_q[7]);
endmodule : amp_ctl_master

// ---- dv/amp_dev_model.sv ----
// behavioural amplifier control port: write-only two-wire slave with its registers
`timescale 1ns/10ps
module amp_dev_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic level_i,
  input wire logic nak_data_i,
  output logic oe_o,
  output logic [7:0] addr_o,
  output logic [7:0] data_o,
  output logic [39:0] regs_o
);
  // ***************************************************************
  // byte decode, slots mode, spatial, mono, left, right
  // ***************************************************************
  function automatic logic [39:0] dec(input logic [39:0] e, input logic [7:0] b);
    if (b[7:6] == 2'b00 && !b[4]) e[7:0] = b;
    else if (b[7:6] == 2'b01) e[15:8] = b;
    else if (b[7:5] == 3'b100) e[23:16] = {3'h0, b[4:0]};
    else if (b[7:5] == 3'b110) e[31:24] = {3'h0, b[4:0]};
    else if (b[7:5] == 3'b111) e[39:32] = {3'h0, b[4:0]};
    return e;
  endfunction : dec
  // ***************************************************************
  // receiver
  // ***************************************************************
  logic [7:0] sh = 8'h00;
  logic ok = 1'b0;
  int cnt = 0;
  int ph = 2;
  initial begin
    oe_o = 1'b0;
    addr_o = 8'h00;
    data_o = 8'h00;
    regs_o = 40'h0;
  end
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    cnt = 0;
    ph = 0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) ph = 2;
  always @(posedge scl_i) if (ph < 2 && cnt < 8) begin
    sh = {sh[6:0], sda_i};
    cnt = cnt + 1;
  end
  // ack driven from clock fall to clock fall so it covers the whole high phase
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      if (ph == 0) begin
        addr_o <= sh;
        ok = (sh == {6'h3E, level_i, 1'b0});
      end else begin
        data_o <= sh;
        ok = !nak_data_i;
      end
      oe_o <= ok;
      cnt = 9;
    end else if (cnt == 9) begin
      oe_o <= 1'b0;
      if (ph == 1 && ok) regs_o <= dec(regs_o, sh);
      ph = (ph == 0 && ok) ? 1 : 2;
      cnt = 0;
    end
  end
endmodule : amp_dev_model

// ---- dv/tb_amp_ctl_master.sv ----
// self-checking bench for the amplifier control master against a device model
`timescale 1ns/10ps
module tb_amp_ctl_master;
  // ***************************************************************
  // clock, wires and instances
  // ***************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic dev_lvl = 1'b0;
  logic nak_d = 1'b0;
  logic [31:0] rdat;
  logic ack, scl, sda_o, sda_oe, dev_oe;
  logic [7:0] dev_addr, dev_data;
  logic [39:0] dev_regs;
  logic [39:0] exp_regs = 40'h0;
  logic [7:0] corner [7] = '{8'h80, 8'h93, 8'hDF, 8'hE0, 8'hFF, 8'h10, 8'hA5};
  wire sda = !(sda_oe | dev_oe); // pull-up wins when nobody pulls
  int miscompares = 0;
  int num_checks = 0;
  realtime t_rise = 0.0;
  initial forever #10 clk_i = ~clk_i;
  amp_ctl_master i_amp_ctl_master (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .scl_o(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe));
  amp_dev_model i_amp_dev_model (.scl_i(scl), .sda_i(sda), .level_i(dev_lvl),
    .nak_data_i(nak_d), .oe_o(dev_oe), .addr_o(dev_addr), .data_o(dev_data),
    .regs_o(dev_regs));
  // ***************************************************************
  // checking and bus tasks
  // ***************************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    // ack rises on the taking edge itself, so it is sampled high one edge later
    cmp(n, 2, "ack latency");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic xfer(input logic [7:0] b, input logic lv, input logic dl, input logic nk);
    logic [31:0] q;
    logic am;
    logic dm;
    int n;
    am = (lv != dl);
    dm = !am && nk;
    dev_lvl <= dl;
    nak_d <= nk;
    wb(1'b1, amp_ctl_pkg::OFS_DATA, {24'h0, b}, 4'hF, q);
    wb(1'b1, amp_ctl_pkg::OFS_DATA, {24'h0, ~b}, 4'hE, q);
    wb(1'b1, amp_ctl_pkg::OFS_CTRL, {30'h0, lv, 1'b1}, 4'hF, q);
    wb(1'b0, amp_ctl_pkg::OFS_STATUS, 32'h0, 4'hF, q);
    cmp(q, 32'h1, "busy after go");
    wb(1'b1, amp_ctl_pkg::OFS_DATA, {24'h0, ~b}, 4'hF, q);
    n = 0;
    do begin
      repeat (40) @(posedge clk_i);
      wb(1'b0, amp_ctl_pkg::OFS_STATUS, 32'h0, 4'hF, q);
      n++;
    end while (q[3] !== 1'b1 && n < 200);
    cmp(q, {28'h0, 1'b1, dm, am, 1'b0}, "status");
    cmp({24'h0, dev_addr}, {24'h0, 6'h3E, lv, 1'b0}, "address byte");
    if (!am) cmp({24'h0, dev_data}, {24'h0, b}, "data byte");
    if (!am && !dm) exp_regs = i_amp_dev_model.dec(exp_regs, b);
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, amp_ctl_pkg::OFS_MODE + 8'(4 * i), 32'h0, 4'hF, q);
      cmp(q, {24'h0, exp_regs[8*i +: 8]}, "shadow");
      cmp({24'h0, dev_regs[8*i +: 8]}, {24'h0, exp_regs[8*i +: 8]}, "device reg");
    end
    wb(1'b0, amp_ctl_pkg::OFS_DATA, 32'h0, 4'hF, q);
    cmp(q, {24'h0, b}, "data kept");
    cmp({30'h0, scl, sda}, 32'h3, "idle lines");
  endtask : xfer
  // ***************************************************************
  // wire monitors and watchdog
  // ***************************************************************
  always @(posedge scl) begin
    if (t_rise > 0.0 && $realtime - t_rise < 2500.0) cmp(0, 1, "clock too fast");
    t_rise = $realtime;
  end
  always @(posedge clk_i) if (!rst_i && sda_o !== 1'b0) cmp(0, 1, "data driven high");
  // budget: about 26 transfers of roughly 2600 cycles each
  initial begin
    #(95000 * 20);
    miscompares++;
    test_done();
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    void'($urandom(88119));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 32; a += 4) begin
      wb(1'b0, 8'(a), 32'h0, 4'hF, q);
      cmp(q, 32'h0, "reset value");
    end
    wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF, q);
    wb(1'b0, 8'h20, 32'h0, 4'hF, q);
    cmp(q, 32'h0, "unmapped");
    for (int i = 0; i < 8; i++) xfer({2'b00, i[0], 1'b0, i[1], i[2:0]}, i[0], i[0], 1'b0);
    for (int i = 0; i < 4; i++) xfer({2'b01, i[1:0], i[1:0], 2'b10}, 1'b1, 1'b1, 1'b0);
    foreach (corner[i]) xfer(corner[i], i[0], i[0], 1'b0);
    xfer(8'hC5, 1'b0, 1'b1, 1'b0);
    xfer(8'hF3, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      r = $urandom;
      xfer(r[7:0], r[8], r[8] ^ (r[10:9] == 2'b00), r[12:11] == 2'b00);
    end
    test_done();
  end
endmodule : tb_amp_ctl_master
